// *** core/tcps_defines.svh ***
// Offsets, field positions, reset values and counts of the tx cell path registers
`ifndef TCPS_DEFINES_SVH
`define TCPS_DEFINES_SVH

// Register indices; byte address is four times the index
`define TCPS_IDX_PERR       8'h53
`define TCPS_IDX_CFG        8'h54
`define TCPS_IDX_RAM        8'h80
`define TCPS_IDX_XFER       8'h86
`define TCPS_IDX_FRAME      8'h87

// Parity error status fields
`define TCPS_PERR_ROLL_BIT  15
`define TCPS_PERR_ANY_BIT   14
`define TCPS_PERR_SNAP_BIT  13
`define TCPS_PERR_CRST_BIT  12
`define TCPS_PERR_RST       16'h0000
`define TCPS_CNT_W          12
`define TCPS_CNT_MAX        12'hFFF

// Cell memory control fields
`define TCPS_RAM_INIT_BIT   6
`define TCPS_RAM_ZERO_BIT   0
`define TCPS_RAM_CTL_W      7
`define TCPS_RAM_CTL_RST    7'h40

// Configuration fields
`define TCPS_CFG_PAR_BIT    0

// Group registers
`define TCPS_GROUPS         8
`define TCPS_GRP_RST        8'hFF

// Memory initialisation length in cycles
`define TCPS_INIT_CYCLES    256
`define TCPS_INIT_CNT_W     16

// Bus responses
`define TCPS_RESP_OKAY      2'h0
`define TCPS_RESP_SLVERR    2'h2

`endif

// *** core/tcps_pkg.sv ***
// Types shared by the tx cell path status and control block
`include "tcps_defines.svh"

package tcps_pkg;

    typedef logic [`TCPS_GROUPS-1:0] tcps_grp_t;

    typedef enum logic {
        TCPS_INIT_IDLE,
        TCPS_INIT_RUN
    } tcps_init_e;

    typedef struct packed {
        logic q;
    } tcps_flag_s;

    typedef struct packed {
        logic                         aw_have;
        logic [7:0]                   aw_idx;
        logic                         w_have;
        logic [15:0]                  wdata;
        logic [15:0]                  wmask;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         rvalid;
        logic [1:0]                   rresp;
        logic [15:0]                  rdata;
        logic                         roll;
        logic                         perr;
        logic                         snap_done;
        logic                         snap_pend;
        logic                         cnt_rst;
        logic [`TCPS_CNT_W-1:0]       snap;
        logic [`TCPS_CNT_W-1:0]       cnt;
        logic                         par_even;
        logic [`TCPS_RAM_CTL_W-1:0]   ram_ctl;
        tcps_init_e                   init_st;
        logic [`TCPS_INIT_CNT_W-1:0]  init_cnt;
    } tcps_state_s;

endpackage : tcps_pkg

// *** core/tcps_flag_bit.sv ***
// One group bit: software writes zero to arm, hardware event sets it
module tcps_flag_bit (
    // Clock and control
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    // Arm and event
    input  wire logic clr,
    input  wire logic set,
    // Flag
    output logic      q
);
    import tcps_pkg::*;

    tcps_flag_s st_reg;
    tcps_flag_s st_next;

    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.q = 1'b0;
        end
        if (set) begin
            st_next.q = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg.q <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;

    // ****************************************
    // Checks
    // ****************************************
    property p_set_wins;
        @(posedge clk) disable iff (srst) ce && set |=> q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost to clear");

    property p_arm;
        @(posedge clk) disable iff (srst) ce && clr && !set |=> !q;
    endproperty
    a_arm: assert property (p_arm) else $error("Write zero did not arm");

    c_arm_then_set: cover property (@(posedge clk) disable iff (srst) !q ##[1:20] q);

endmodule : tcps_flag_bit

// *** core/tcps_regs.sv ***
// Tx cell path parity, memory init, control-cell transfer and frame registers
//
// Functional notes
// - Counter wrap sets sticky bit 15
// - Any parity error sets sticky bit 14
// - Write one to bit 13 snapshots count
// - Bit 13 reads one once snapshot done
// - Bit 12 high holds counter in reset
// - Bit 7 low while memory initialises
// - Memory control resets with bit 6 set
// - Write zero starts group transfer, done sets
// - Transfer bits ignore ones, reset 00FF
// - Write zero arms, reference cell sets
// - Frame bits ignore ones, reset 00FF
// - Upper byte of group registers reads zero
// - Four-link variant: only groups 0-3 work
// - Parity status register resets to zero
// - Parity odd when select zero, else even
module tcps_regs #(
    parameter int AW            = 12,
    parameter int DW            = 16,
    parameter int ACTIVE_GROUPS = `TCPS_GROUPS,
    parameter int INIT_CYCLES   = `TCPS_INIT_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        ce,
    // AXI4-Lite slave
    input  wire logic [AW-1:0]               s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [AW-1:0]               s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Transmit cell bus
    input  wire logic [DW-1:0]               tx_bus_data,
    input  wire logic                        tx_bus_par,
    input  wire logic                        tx_bus_valid,
    // Cell memory initialisation
    output logic                             init_wr_en,
    output logic [`TCPS_INIT_CNT_W-1:0]      init_wr_addr,
    // Per-group control cells
    output tcps_pkg::tcps_grp_t              xfer_req,
    input  wire tcps_pkg::tcps_grp_t         xfer_done,
    input  wire tcps_pkg::tcps_grp_t         ref_cell_sent
);
    import tcps_pkg::*;

    localparam logic [`TCPS_INIT_CNT_W-1:0] INIT_LAST = `TCPS_INIT_CNT_W'(INIT_CYCLES - 1);

    tcps_state_s st_reg;
    tcps_state_s st_next;

    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;
    logic        wr_fire;
    logic [7:0]  aw_idx_in;
    logic [7:0]  ar_idx;
    logic [15:0] wz;
    logic [15:0] wo;
    logic        wr_perr;
    logic        wr_ram;
    logic        wr_cfg;
    logic        par_err;
    logic        roll_evt;
    logic        init_start;
    logic        ram_ready;
    logic [15:0] rd_val;
    tcps_grp_t   xfer_q;
    tcps_grp_t   frame_q;
    tcps_grp_t   xfer_clr;
    tcps_grp_t   frame_clr;

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx inside {`TCPS_IDX_PERR, `TCPS_IDX_CFG, `TCPS_IDX_RAM,
                           `TCPS_IDX_XFER, `TCPS_IDX_FRAME};
    endfunction : is_mapped

    // ****************************************
    // Bus handshakes and decode
    // ****************************************
    // Nothing is taken while the block is frozen
    assign s_axi_awready = ce & ~st_reg.aw_have;
    assign s_axi_wready  = ce & ~st_reg.w_have;
    assign s_axi_arready = ce & ~st_reg.rvalid;
    assign s_axi_bvalid  = ce & st_reg.bvalid;
    assign s_axi_rvalid  = ce & st_reg.rvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = {16'h0000, st_reg.rdata};

    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire  = s_axi_wvalid & s_axi_wready;
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    // Out-of-range upper address bits fold to unmapped index zero
    assign aw_idx_in = (s_axi_awaddr[AW-1:10] == '0) ? s_axi_awaddr[9:2] : 8'h00;
    assign ar_idx    = (s_axi_araddr[AW-1:10] == '0) ? s_axi_araddr[9:2] : 8'h00;
    // Write runs once address and data are both held
    assign wr_fire = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
    assign wz      = st_reg.wmask & ~st_reg.wdata;
    assign wo      = st_reg.wmask & st_reg.wdata;
    assign wr_perr = wr_fire & (st_reg.aw_idx == `TCPS_IDX_PERR);
    assign wr_ram  = wr_fire & (st_reg.aw_idx == `TCPS_IDX_RAM);
    assign wr_cfg  = wr_fire & (st_reg.aw_idx == `TCPS_IDX_CFG);

    // ****************************************
    // Parity checking and memory init
    // ****************************************
    // odd or even by select
    assign par_err  = tx_bus_valid & ((^{tx_bus_data, tx_bus_par}) == st_reg.par_even);
    assign roll_evt = par_err & ~st_reg.cnt_rst & (st_reg.cnt == `TCPS_CNT_MAX);
    assign init_start = wr_ram & wz[`TCPS_RAM_INIT_BIT] & wz[`TCPS_RAM_ZERO_BIT]
                      & (st_reg.init_st == TCPS_INIT_IDLE);
    assign ram_ready    = (st_reg.init_st == TCPS_INIT_IDLE);
    assign init_wr_en   = ~ram_ready;
    assign init_wr_addr = st_reg.init_cnt;

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        case (ar_idx)
            `TCPS_IDX_PERR:  rd_val = {st_reg.roll, st_reg.perr, st_reg.snap_done,
                                       st_reg.cnt_rst, st_reg.snap};
            `TCPS_IDX_CFG:   rd_val = {15'h0000, st_reg.par_even};
            `TCPS_IDX_RAM:   rd_val = {8'h00, ram_ready, st_reg.ram_ctl};
            `TCPS_IDX_XFER:  rd_val = {8'h00, xfer_q};
            `TCPS_IDX_FRAME: rd_val = {8'h00, frame_q};
            default:         rd_val = 16'h0000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        // Bus channels
        if (aw_fire) begin
            st_next.aw_have = 1'b1;
            st_next.aw_idx  = aw_idx_in;
        end
        if (w_fire) begin
            st_next.w_have = 1'b1;
            st_next.wdata  = s_axi_wdata[15:0];
            st_next.wmask  = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end
        if (wr_fire) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = is_mapped(st_reg.aw_idx) ? `TCPS_RESP_OKAY : `TCPS_RESP_SLVERR;
        end else if (s_axi_bvalid & s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (ar_fire) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_val;
            st_next.rresp  = is_mapped(ar_idx) ? `TCPS_RESP_OKAY : `TCPS_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // count bad words, wrap at max
        if (par_err) begin
            st_next.cnt = st_reg.cnt + 12'h001;
        end
        // held in reset by control bit
        if (st_reg.cnt_rst) begin
            st_next.cnt = 12'h000;
        end
        if (st_reg.snap_pend) begin
            st_next.snap      = st_reg.cnt;
            st_next.snap_done = 1'b1;
            st_next.snap_pend = 1'b0;
        end
        if (wr_perr) begin
            if (wz[`TCPS_PERR_ROLL_BIT]) begin
                st_next.roll = 1'b0;
            end
            if (wz[`TCPS_PERR_ANY_BIT]) begin
                st_next.perr = 1'b0;
            end
            if (wo[`TCPS_PERR_SNAP_BIT]) begin
                st_next.snap_pend = 1'b1;
                st_next.snap_done = 1'b0;
            end
            if (st_reg.wmask[`TCPS_PERR_CRST_BIT]) begin
                st_next.cnt_rst = st_reg.wdata[`TCPS_PERR_CRST_BIT];
            end
        end
        if (roll_evt) begin
            st_next.roll = 1'b1;
        end
        if (par_err) begin
            st_next.perr = 1'b1;
        end

        if (wr_cfg & st_reg.wmask[`TCPS_CFG_PAR_BIT]) begin
            st_next.par_even = st_reg.wdata[`TCPS_CFG_PAR_BIT];
        end
        // Reserved bits are stored as written
        if (wr_ram) begin
            st_next.ram_ctl = (st_reg.ram_ctl & ~st_reg.wmask[6:0])
                            | (st_reg.wdata[6:0] & st_reg.wmask[6:0]);
        end

        case (st_reg.init_st)
            TCPS_INIT_IDLE: begin
                if (init_start) begin
                    st_next.init_st  = TCPS_INIT_RUN;
                    st_next.init_cnt = '0;
                end
            end
            TCPS_INIT_RUN: begin
                st_next.init_cnt = st_reg.init_cnt + 16'h0001;
                if (st_reg.init_cnt == INIT_LAST) begin
                    st_next.init_st  = TCPS_INIT_IDLE;
                    st_next.init_cnt = '0;
                end
            end
            default: begin
                st_next.init_st = TCPS_INIT_IDLE;
            end
        endcase
    end

    // bit 6 taken as one at reset
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg         <= '0;
            st_reg.ram_ctl <= `TCPS_RAM_CTL_RST;
            st_reg.init_st <= TCPS_INIT_IDLE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Group bits
    // ****************************************
    generate
        for (genvar g = 0; g < `TCPS_GROUPS; g++) begin : g_grp
            if (g < ACTIVE_GROUPS) begin : g_on
                assign xfer_clr[g]  = wr_fire & (st_reg.aw_idx == `TCPS_IDX_XFER) & wz[g];
                assign frame_clr[g] = wr_fire & (st_reg.aw_idx == `TCPS_IDX_FRAME) & wz[g];
                tcps_flag_bit u_xfer (
                    .clk  (clk),
                    .srst (srst),
                    .ce   (ce),
                    .clr  (xfer_clr[g]),
                    .set  (xfer_done[g]),
                    .q    (xfer_q[g])
                );
                tcps_flag_bit u_frame (
                    .clk  (clk),
                    .srst (srst),
                    .ce   (ce),
                    .clr  (frame_clr[g]),
                    .set  (ref_cell_sent[g]),
                    .q    (frame_q[g])
                );
            end else begin : g_off
                assign xfer_clr[g]  = 1'b0;
                assign frame_clr[g] = 1'b0;
                assign xfer_q[g]    = 1'b1;
                assign frame_q[g]   = 1'b1;
            end
        end
    endgenerate

    // Transfer request stays up until the group reports completion
    assign xfer_req = ~xfer_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_roll;
        ce && roll_evt |=> st_reg.roll && st_reg.cnt == 12'h000;
    endproperty
    a_roll: assert property (p_roll) else $error("Wrap did not set rollover");

    property p_perr;
        ce && par_err |=> st_reg.perr;
    endproperty
    a_perr: assert property (p_perr) else $error("Parity error not flagged");

    property p_snap;
        ce && st_reg.snap_pend |=> st_reg.snap_done && st_reg.snap == $past(st_reg.cnt);
    endproperty
    a_snap: assert property (p_snap) else $error("Snapshot wrong");

    property p_snap_req;
        ce && wr_perr && wo[13] |=> st_reg.snap_pend && !st_reg.snap_done;
    endproperty
    a_snap_req: assert property (p_snap_req) else $error("Update bit not low");

    property p_cnt_hold;
        ce && st_reg.cnt_rst |=> st_reg.cnt == 12'h000;
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("Counter ran in reset");

    property p_init;
        ce && init_start |=> !ram_ready && init_wr_en && init_wr_addr == 16'h0000;
    endproperty
    a_init: assert property (p_init) else $error("Init did not start");

    property p_xfer;
        ce && xfer_clr[0] && !xfer_done[0] |=> xfer_req[0];
    endproperty
    a_xfer: assert property (p_xfer) else $error("Transfer not started");

    property p_frame;
        ce && ref_cell_sent[0] |=> frame_q[0];
    endproperty
    a_frame: assert property (p_frame) else $error("Frame bit not set");

    property p_upper;
        ar_fire && ar_idx inside {`TCPS_IDX_RAM, `TCPS_IDX_XFER, `TCPS_IDX_FRAME}
            |=> st_reg.rdata[15:8] == 8'h00;
    endproperty
    a_upper: assert property (p_upper) else $error("Upper byte not zero");

    property p_perr_rst;
        @(posedge clk) disable iff (1'b0)
            srst |=> {st_reg.roll, st_reg.perr, st_reg.snap_done, st_reg.cnt_rst,
                      st_reg.snap} == `TCPS_PERR_RST;
    endproperty
    a_perr_rst: assert property (p_perr_rst) else $error("Parity status not reset");

    c_roll:     cover property (ce && roll_evt);
    c_init_end: cover property (!ram_ready ##1 ram_ready);
    c_xfer:     cover property (xfer_req[0] ##[1:50] !xfer_req[0]);
    c_slverr:   cover property (s_axi_rvalid && s_axi_rresp == `TCPS_RESP_SLVERR);

endmodule : tcps_regs

// *** bench/tcps_far_model.sv ***
// Far-side model: cell bus source and control-cell engine
module tcps_far_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Bench controls
    input  wire logic       cb_go,
    input  wire logic       cb_bad,
    input  wire logic       par_even,
    input  wire logic [5:0] lag,
    input  wire logic [7:0] ref_go,
    // Toward and from the block
    input  wire logic [7:0] xfer_req,
    output logic [15:0]     tx_bus_data = '0,
    output logic            tx_bus_par = 1'b0,
    output logic            tx_bus_valid = 1'b0,
    output logic [7:0]      xfer_done = '0,
    output logic [7:0]      ref_cell_sent = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  cnt [8] = '{default: 6'h00};
    logic [15:0] d;
    // ****************************************
    // Cell bus words and transfer completion
    // ****************************************
    always @(posedge clk) begin
        // Data keeps changing while idle, so a stale word never looks valid
        d = 16'($urandom);
        tx_bus_data   <= d;
        tx_bus_valid  <= cb_go;
        tx_bus_par    <= ^d ^ par_even ^ !cb_bad;
        ref_cell_sent <= ref_go;
        for (int g = 0; g < 8; g++) begin
            xfer_done[g] <= 1'b0;
            if (srst || !xfer_req[g]) begin
                cnt[g] <= 6'h00;
            end else if (cnt[g] == lag) begin
                xfer_done[g] <= 1'b1;
                cnt[g]       <= 6'h00;
            end else begin
                cnt[g] <= cnt[g] + 6'h01;
            end
        end
    end
endmodule : tcps_far_model

// *** bench/tx_cell_path_status_control_tb.sv ***
// Self-checking bench for the tx cell path status and control registers
module tx_cell_path_status_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INITC = 16;
    logic        clk = 0, srst = 1, ce = 1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] tx_bus_data, init_wr_addr;
    logic        tx_bus_par, tx_bus_valid, init_wr_en;
    logic [7:0]  xfer_req, xfer_done, ref_cell_sent, ref_go = '0, v;
    logic        cb_go = 0, cb_bad = 0, par_even = 0;
    logic [5:0]  lag = 6'd1;
    logic [11:0] ga;
    logic [1:0]  rs;
    logic [31:0] rd;
    int          n_mismatch = 0, n_compared = 0, n_init = 0, cyc = 0, nb;
    logic [11:0] ra [5] = '{12'h14C, 12'h150, 12'h200, 12'h218, 12'h21C};
    logic [31:0] re [5] = '{32'h0, 32'h0, 32'hC0, 32'hFF, 32'hFF};

    tcps_regs #(.INIT_CYCLES(INITC)) tcps_regs_i (.clk, .srst, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tx_bus_data, .tx_bus_par, .tx_bus_valid,
        .init_wr_en, .init_wr_addr, .xfer_req, .xfer_done, .ref_cell_sent);
    tcps_far_model tcps_far_model_i (.clk, .srst, .cb_go, .cb_bad, .par_even, .lag,
        .ref_go, .xfer_req, .tx_bus_data, .tx_bus_par, .tx_bus_valid, .xfer_done,
        .ref_cell_sent);

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Readies are looked at on the falling edge so the handshake edge is race free
    task automatic axw(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
                       output logic [1:0] r);
        logic ap, wp;
        ap = 1;
        wp = 1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            if (s_axi_awready === 1'b1) ap = 0;
            if (s_axi_wready === 1'b1) wp = 0;
            @(posedge clk);
            if (!ap) s_axi_awvalid <= 1'b0;
            if (!wp) s_axi_wvalid <= 1'b0;
        end while (ap || wp);
        do @(negedge clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (s_axi_arready !== 1'b1);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [1:0] r;
        axw(a, d, s, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axr(a, d, r);
        chk(nm, e, d);
        chk("rresp", 32'h0, {30'h0, r});
    endtask : rdc
    task automatic send(input int n, input logic all);
        int   k;
        logic b;
        k = 0;
        while (k < n) begin
            b = all || ($urandom_range(0, 2) != 0);
            if (b) k++;
            @(posedge clk);
            cb_go <= 1'b1;
            cb_bad <= b;
        end
        @(posedge clk);
        cb_go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send

    // ****************************************
    // Clock, timeout, monitor, sequence
    // ****************************************
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    always @(negedge clk) begin
        if (init_wr_en === 1'b1) begin
            chk("init_addr", 32'(n_init), {16'h0, init_wr_addr});
            n_init++;
        end
    end
    initial begin
        void'($urandom(63));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) rdc("reset", ra[i], re[i]);
        axr(12'h004, rd, rs);
        chk("unmapped_rresp", 32'h2, {30'h0, rs});
        chk("unmapped_rdata", 32'h0, rd);
        axw(12'h800, 16'hFFFF, 4'h3, rs);
        chk("unmapped_bresp", 32'h2, {30'h0, rs});
        for (int m = 0; m < 2; m++) begin
            wr(12'h150, 16'(m), 4'h3);
            par_even <= m[0];
            wr(12'h14C, 16'h1000, 4'h3);
            wr(12'h14C, 16'h0000, 4'h3);
            nb = $urandom_range(1, 40);
            send(nb, 1'b0);
            if (m == 0) rdc("no_snap", 12'h14C, 32'h4000);
            wr(12'h14C, 16'hE000, 4'h3);
            rdc("snap", 12'h14C, 32'h6000 | 32'(nb));
        end
        wr(12'h14C, 16'h1000, 4'h3);
        send(5, 1'b0);
        wr(12'h14C, 16'hF000, 4'h3);
        rdc("held", 12'h14C, 32'h7000);
        wr(12'h14C, 16'h0000, 4'h3);
        rdc("cleared", 12'h14C, 32'h2000);
        send(4096, 1'b1);
        wr(12'h14C, 16'hE000, 4'h3);
        rdc("roll", 12'h14C, 32'hE000);
        wr(12'h200, 16'h0000, 4'h1);
        rdc("init_busy", 12'h200, 32'h0);
        while (n_init < INITC) @(negedge clk);
        rdc("init_done", 12'h200, 32'h80);
        chk("init_len", 32'(INITC), 32'(n_init));
        wr(12'h200, 16'h0040, 4'h1);
        rdc("ram_ctl", 12'h200, 32'hC0);
        for (int r = 0; r < 2; r++) begin
            ga = (r == 1) ? 12'h21C : 12'h218;
            v = 8'($urandom);
            v[0] = 1'b0;
            lag <= 6'd40;
            wr(ga, {8'h00, v}, 4'h3);
            wr(ga, 16'hFFFF, 4'h3);
            rdc("armed", ga, {24'h0, v});
            if (r == 0) begin
                // Flop output, so look away from the edge that launches it
                @(negedge clk);
                chk("xfer_req", {24'h0, ~v}, {24'h0, xfer_req});
            end else begin
                @(posedge clk);
                ref_go <= ~v;
                @(posedge clk);
                ref_go <= '0;
            end
            repeat (50) @(posedge clk);
            rdc("fired", ga, 32'hFF);
        end
        lag <= 6'd1;
        wr(12'h218, 16'h0000, 4'h3);
        repeat (4) @(posedge clk);
        rdc("prompt", 12'h218, 32'hFF);
        give_verdict();
    end
endmodule : tx_cell_path_status_control_tb
